/* include/dbghc_map.svh */
// Constants for the debug hardware command decoder.
// Assumes inclusion by bare name from the design and bench files.
`ifndef DBGHC_MAP_SVH
`define DBGHC_MAP_SVH
// ==========================================================
// Opcodes
`define DBGHC_OP_BACKGROUND 8'h90
`define DBGHC_OP_ACK_ON 8'hD5
`define DBGHC_OP_ACK_OFF 8'hD6
`define DBGHC_OP_RD_DBG_BYTE 8'hE4
`define DBGHC_OP_RD_DBG_WORD 8'hEC
`define DBGHC_OP_RD_APP_BYTE 8'hE0
`define DBGHC_OP_RD_APP_WORD 8'hE8
`define DBGHC_OP_WR_DBG_BYTE 8'hC4
`define DBGHC_OP_WR_DBG_WORD 8'hCC
`define DBGHC_OP_WR_APP_BYTE 8'hC0
`define DBGHC_OP_WR_APP_WORD 8'hC8
// ==========================================================
// Debug window in the memory map
`define DBGHC_WIN_BASE 16'hFF00
`define DBGHC_WIN_MASK 16'hFF00
// ==========================================================
// Timing
`define DBGHC_ACK_NS 16
`define DBGHC_CLK_NS 4
`define DBGHC_ACK_CYC ((`DBGHC_ACK_NS + `DBGHC_CLK_NS - 1) / `DBGHC_CLK_NS)
`endif

/* include/dbghc_pkg.sv */
// Types for the debug hardware command decoder.
// Assumes the constants header is on the include path.
package dbghc_pkg;
	// ==========================================================
	// Command request from the link side
	typedef struct packed {
		logic [7:0] opcode;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dbghc_cmd_type;
	// ==========================================================
	// Memory request toward the system bus
	typedef struct packed {
		logic req;
		logic wr;
		logic dbg_sel;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [1:0] be;
	} dbghc_mem_type;
	typedef enum logic [2:0] {
		DBGHC_IDLE = 3'h0,
		DBGHC_ACCESS = 3'h1,
		DBGHC_WAIT = 3'h3,
		DBGHC_ACKP = 3'h2
	} dbghc_state_type;
endpackage

/* hw/dbghc_pulse.sv */
// Fixed-length acknowledge pulse generator.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`include "dbghc_map.svh"
module dbghc_pulse import dbghc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fire,
	output logic pulse
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	// ==========================================================
	// Counter
	always_comb begin
		cnt_next = cnt_reg;
		if (fire) begin
			cnt_next = 4'(`DBGHC_ACK_CYC);
		end else if (cnt_reg != 4'h0) begin
			cnt_next = cnt_reg - 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	assign pulse = (cnt_reg != 4'h0);
endmodule // dbghc_pulse

/* hw/dbghc_decoder.sv */
// Hardware command decoder of the background debug port.
// Assumes the serial link front end delivers decoded commands with a valid strobe,
// and the system bus answers memory requests with a done pulse.
// Operation
// - Enter-background opcode enters background mode only if firmware enabled; ack then.
// - Handshake-enable opcode turns acknowledge on and acknowledges itself.
// - Handshake-disable opcode turns acknowledge off without acknowledging.
// - In-map reads take 16-bit address, return 16-bit data.
// - Out-of-map reads take 16-bit address, return application data.
// - In-map writes take address and data and store them.
// - Out-of-map writes take address and data, write application memory.
// - Byte data: odd address in low byte, even address in high byte.
// - Read acknowledge comes when read data is ready.
// - Write acknowledge comes after the write has completed.
// - Debug resources selected only during an in-map access.
// - Normal execution suspended while in background mode.
// - Background mode maps debug table at 0xFF00-0xFFFF.
`timescale 1ns/1ps
`include "dbghc_map.svh"
module dbghc_decoder import dbghc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire dbghc_cmd_type cmd,
	output logic cmd_ready,
	input wire logic fw_enable,
	input wire logic bg_exit,
	output dbghc_mem_type mem,
	input wire logic mem_done,
	input wire logic [15:0] mem_rdata,
	output logic [15:0] rdata,
	output logic rdata_valid,
	output logic ack_pulse,
	output logic ack_enabled,
	output logic background_debug_mode,
	output logic cpu_halt,
	output logic dbg_window_on
);

	// Sequencer state, request, mode flags and their next values
	dbghc_state_type state_reg, state_next;
	dbghc_mem_type mem_reg, mem_next;
	logic ack_en_reg, ack_en_next;
	logic bdm_reg, bdm_next;
	logic [15:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic fire;
	// Decoded opcode class; known stays high for the three control opcodes
	logic is_rd, is_wr, is_dbg, is_byte, known;
	// Check helpers: a taken command, and a request address in the top page
	logic take;
	logic in_window;

	// ==========================================================
	// Opcode classification
	// Fully decoded, so any stray opcode falls to the default and is dropped
	always_comb begin
		is_rd = 1'b0;
		is_wr = 1'b0;
		is_dbg = 1'b0;
		is_byte = 1'b0;
		known = 1'b1;
		case (cmd.opcode)
			`DBGHC_OP_RD_DBG_BYTE: begin is_rd = 1'b1; is_dbg = 1'b1; is_byte = 1'b1; end
			`DBGHC_OP_RD_DBG_WORD: begin is_rd = 1'b1; is_dbg = 1'b1; end
			`DBGHC_OP_RD_APP_BYTE: begin is_rd = 1'b1; is_byte = 1'b1; end
			`DBGHC_OP_RD_APP_WORD: begin is_rd = 1'b1; end
			`DBGHC_OP_WR_DBG_BYTE: begin is_wr = 1'b1; is_dbg = 1'b1; is_byte = 1'b1; end
			`DBGHC_OP_WR_DBG_WORD: begin is_wr = 1'b1; is_dbg = 1'b1; end
			`DBGHC_OP_WR_APP_BYTE: begin is_wr = 1'b1; is_byte = 1'b1; end
			`DBGHC_OP_WR_APP_WORD: begin is_wr = 1'b1; end
			`DBGHC_OP_BACKGROUND, `DBGHC_OP_ACK_ON, `DBGHC_OP_ACK_OFF: begin end
			default: known = 1'b0;
		endcase
	end

	// ==========================================================
	// Command sequencer
	// Controls finish in the take cycle; only memory commands leave idle.
	// The ready gap after an access keeps a new take off the acknowledge start.
	always_comb begin
		state_next = state_reg;
		mem_next = mem_reg;
		ack_en_next = ack_en_reg;
		bdm_next = bdm_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		fire = 1'b0;
		// Exit first, so an entry in the same cycle wins
		if (bg_exit) begin
			bdm_next = 1'b0;
		end
		case (state_reg)
			DBGHC_IDLE: begin
				if (cmd_valid && known) begin
					if (cmd.opcode == `DBGHC_OP_BACKGROUND) begin
						if (fw_enable) begin
							bdm_next = 1'b1;
							fire = ack_en_reg;
						end
					end else if (cmd.opcode == `DBGHC_OP_ACK_ON) begin
						ack_en_next = 1'b1;
						fire = 1'b1;
					end else if (cmd.opcode == `DBGHC_OP_ACK_OFF) begin
						ack_en_next = 1'b0;
					end else if (is_rd || is_wr) begin
						// Byte lanes: even address is high lane
						mem_next.req = 1'b1;
						mem_next.wr = is_wr;
						mem_next.dbg_sel = is_dbg;
						mem_next.addr = cmd.addr;
						mem_next.wdata = cmd.wdata;
						mem_next.be = !is_byte ? 2'h3 : (cmd.addr[0] ? 2'h1 : 2'h2);
						state_next = DBGHC_ACCESS;
					end
				end
			end
			DBGHC_ACCESS: begin
				// Request held until the bus answers
				if (mem_done) begin
					// Request dropped here; the lane not addressed reads back zero
					mem_next = '0;
					if (!mem_reg.wr) begin
						rdata_next = mem_reg.be == 2'h1 ? {8'h00, mem_rdata[7:0]} :
							mem_reg.be == 2'h2 ? {mem_rdata[15:8], 8'h00} : mem_rdata;
						rvalid_next = 1'b1;
					end
					state_next = DBGHC_WAIT;
				end
			end
			DBGHC_WAIT: begin
				// Data ready or write complete before acknowledging
				// Read data already stands on rdata in this beat
				fire = ack_en_reg;
				state_next = DBGHC_ACKP;
			end
			DBGHC_ACKP: begin
				// One spare beat before ready returns
				state_next = DBGHC_IDLE;
			end
			default: state_next = DBGHC_IDLE;
		endcase
	end

	// Register update; reset leaves every output low and ready high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= DBGHC_IDLE;
			mem_reg <= '0;
			ack_en_reg <= 1'b0;
			bdm_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			mem_reg <= mem_next;
			ack_en_reg <= ack_en_next;
			bdm_reg <= bdm_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ==========================================================
	// Acknowledge pulse
	// A new fire restarts the count rather than queueing a second pulse
	dbghc_pulse i_dbghc_pulse (
		.clk(clk),
		.rst_n(rst_n),
		.fire(fire),
		.pulse(ack_pulse)
	);

	// ==========================================================
	// Outputs
	// Ready is combinational so the host sees the idle beat at once
	assign cmd_ready = (state_reg == DBGHC_IDLE);
	assign mem = mem_reg;
	assign rdata = rdata_reg;
	assign rdata_valid = rvalid_reg;
	assign ack_enabled = ack_en_reg;
	assign background_debug_mode = bdm_reg;
	assign cpu_halt = bdm_reg;
	assign dbg_window_on = bdm_reg; // Top page mapped

	// ==========================================================
	// Check helpers
	assign take = cmd_valid && cmd_ready;
	assign in_window = (mem.addr & `DBGHC_WIN_MASK) == `DBGHC_WIN_BASE;

	// ==========================================================
	// Checks: opcode handling and handshake
	unk_no_access_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_ready && !known |=> !mem.req && !ack_pulse)
		else $error("unknown opcode acted on");
	bg_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_ready && cmd.opcode == `DBGHC_OP_BACKGROUND && fw_enable && !bg_exit
		|=> background_debug_mode)
		else $error("background entry missed");
	bg_blocked_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_ready && cmd.opcode == `DBGHC_OP_BACKGROUND && !fw_enable
		&& !background_debug_mode |=> !background_debug_mode)
		else $error("background entered without firmware");
	ack_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_ready && cmd.opcode == `DBGHC_OP_ACK_ON |=> ##1 ack_pulse && ack_enabled)
		else $error("handshake enable not acknowledged");
	ack_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_ready && cmd.opcode == `DBGHC_OP_ACK_OFF && !ack_pulse
		|=> !ack_enabled ##1 !ack_pulse)
		else $error("handshake disable acknowledged");

	// ==========================================================
	// Checks: acknowledge timing, selects and lanes
	rd_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata_valid && ack_enabled |=> ##1 ack_pulse)
		else $error("read acknowledge missing");
	wr_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && mem.wr && !mem_done |-> !ack_pulse || $past(ack_pulse, 1))
		else $error("write acknowledged early");
	dbg_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.dbg_sel |-> mem.req)
		else $error("debug select outside access");
	byte_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata_valid && $past(mem.be) == 2'h1 |-> rdata[15:8] == 8'h00)
		else $error("odd byte lane wrong");
	halt_a: assert property (@(posedge clk) disable iff (!rst_n)
		background_debug_mode |-> cpu_halt && dbg_window_on)
		else $error("execution not suspended");

	// ==========================================================
	// Checks: request toward the bus
	// Request fields stand unchanged until the bus answers
	mem_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && !mem_done |=> mem.req && $stable(mem.addr) && $stable(mem.be)
		&& $stable(mem.wr) && $stable(mem.dbg_sel))
		else $error("memory request changed while waiting");
	mem_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && mem_done |=> !mem.req && !mem.dbg_sel)
		else $error("debug select held after access");
	// Each opcode family reaches the bus with its own direction and select
	rd_dbg_req_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && cmd.opcode == `DBGHC_OP_RD_DBG_BYTE
		|=> mem.req && !mem.wr && mem.dbg_sel && mem.addr == $past(cmd.addr))
		else $error("in-map byte read not issued");
	rd_app_req_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && cmd.opcode == `DBGHC_OP_RD_APP_WORD
		|=> mem.req && !mem.wr && !mem.dbg_sel && mem.be == 2'h3)
		else $error("application word read not issued");
	wr_dbg_req_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && cmd.opcode == `DBGHC_OP_WR_DBG_WORD
		|=> mem.req && mem.wr && mem.dbg_sel && mem.wdata == $past(cmd.wdata))
		else $error("in-map word write not issued");
	wr_app_req_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && cmd.opcode == `DBGHC_OP_WR_APP_BYTE
		|=> mem.req && mem.wr && !mem.dbg_sel && mem.wdata == $past(cmd.wdata))
		else $error("application byte write not issued");
	byte_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && mem.be != 2'h3 |-> mem.be == {!mem.addr[0], mem.addr[0]})
		else $error("byte lane select wrong");

	// ==========================================================
	// Checks: data and acknowledge after the access
	rd_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && !mem.wr && mem.be == 2'h3 && mem_done
		|=> rdata_valid && rdata == $past(mem_rdata))
		else $error("word read data lost");
	even_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata_valid && $past(mem.be) == 2'h2 |-> rdata[7:0] == 8'h00)
		else $error("even byte lane wrong");
	// Read data must not move while its acknowledge goes out
	rd_stand_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata_valid |=> $stable(rdata) ##1 $stable(rdata))
		else $error("read data moved before acknowledge");
	wr_done_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.req && mem.wr && mem_done |=> !rdata_valid ##1 (ack_pulse == ack_enabled))
		else $error("write completion acknowledge wrong");
	// With handshake off a read stays silent
	rd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata_valid && !ack_enabled |=> ##1 !ack_pulse)
		else $error("read acknowledged with handshake off");

	// ==========================================================
	// Checks: mode changes
	unk_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && !known && !bg_exit |=> cmd_ready && $stable(ack_enabled)
		&& $stable(background_debug_mode))
		else $error("unknown opcode changed state");
	bg_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && cmd.opcode == `DBGHC_OP_BACKGROUND && fw_enable && ack_enabled
		|=> background_debug_mode && ack_pulse)
		else $error("background entry not acknowledged");
	bg_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
		bg_exit && !(take && cmd.opcode == `DBGHC_OP_BACKGROUND && fw_enable)
		|=> !background_debug_mode && !cpu_halt && !dbg_window_on)
		else $error("execution left suspended");

	// ==========================================================
	// Covers
	rd_cov: cover property (@(posedge clk) disable iff (!rst_n) rdata_valid && ack_enabled);
	wr_cov: cover property (@(posedge clk) disable iff (!rst_n) mem.req && mem.wr && mem_done);
	bg_cov: cover property (@(posedge clk) disable iff (!rst_n)
		!background_debug_mode ##1 background_debug_mode);
	odd_rd_cov: cover property (@(posedge clk) disable iff (!rst_n)
		rdata_valid && $past(mem.be) == 2'h1);
	dbg_win_cov: cover property (@(posedge clk) disable iff (!rst_n)
		mem.req && mem.dbg_sel && in_window);
endmodule // dbghc_decoder

/* verif/dbghc_mem_model.sv */
// Memory-bus responder standing behind the debug command decoder.
// Assumes one clock; answers each held request after a random wait.
`timescale 1ns/1ps
module dbghc_mem_model import dbghc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire dbghc_mem_type mem,
	output logic mem_done = 1'b0,
	output logic [15:0] mem_rdata = 16'h5A5A
);
	integer seed = 7;
	integer wait_cnt = 0;
	// ==========================================================
	// Answer after 1..4 cycles; idle data toggles so stale data never looks valid
	always @(posedge clk) begin
		if (!rst_n || mem_done || !mem.req) begin
			mem_done <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt <= 1 + ($unsigned($random(seed)) % 4);
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
			mem_rdata <= ~mem_rdata;
		end else begin
			mem_done <= 1'b1;
			mem_rdata <= {mem.addr[7:0], ~mem.addr[15:8]};
		end
	end
endmodule // dbghc_mem_model

/* verif/tb_dbghc_decoder.sv */
// Self-checking bench for the debug hardware command decoder.
// Assumes the memory responder model; results are compared from queues.
`timescale 1ns/1ps
`include "dbghc_map.svh"
module tb_dbghc_decoder import dbghc_pkg::*;;
	logic clk = 1'b0;
	logic rst_n, cmd_valid, cmd_ready, fw_enable, bg_exit, mem_done, rdata_valid, ack_pulse;
	logic ack_enabled, background_debug_mode, cpu_halt, dbg_window_on, req_prev, hs;
	dbghc_cmd_type cmd;
	dbghc_mem_type mem, m;
	logic [15:0] mem_rdata, rdata, p;
	logic [7:0] ops [8] = '{8'hE4, 8'hEC, 8'hE0, 8'hE8, 8'hC4, 8'hCC, 8'hC0, 8'hC8};
	logic [15:0] exp_rd [$];
	dbghc_mem_type exp_mem [$];
	integer seed = 31706;
	integer mismatches = 0, compares = 0, acks = 0, exp_acks = 0, ack_hi = 0;
	always #2 clk = ~clk;
	dbghc_decoder i_dbghc_decoder (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .fw_enable(fw_enable), .bg_exit(bg_exit), .mem(mem),
		.mem_done(mem_done), .mem_rdata(mem_rdata), .rdata(rdata), .rdata_valid(rdata_valid),
		.ack_pulse(ack_pulse), .ack_enabled(ack_enabled),
		.background_debug_mode(background_debug_mode), .cpu_halt(cpu_halt),
		.dbg_window_on(dbg_window_on));
	dbghc_mem_model i_dbghc_mem_model (.clk(clk), .rst_n(rst_n), .mem(mem),
		.mem_done(mem_done), .mem_rdata(mem_rdata));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// One command: note the expected access, data and acknowledge, then issue it
	task automatic send(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
		logic is_mem;
		is_mem = op[7:6] == 2'b11 && !op[4] && op[1:0] == 2'b00;
		if (op == `DBGHC_OP_ACK_ON) hs = 1'b1;
		if (op == `DBGHC_OP_ACK_OFF) hs = 1'b0;
		if (hs && (is_mem || op == `DBGHC_OP_ACK_ON ||
			(op == `DBGHC_OP_BACKGROUND && fw_enable))) exp_acks++;
		p = {a[7:0], ~a[15:8]};
		if (is_mem) begin
			exp_mem.push_back('{1'b1, !op[5], op[2], a, op[5] ? 16'h0000 : d,
				op[3] ? 2'b11 : {!a[0], a[0]}});
			if (op[5]) exp_rd.push_back(op[3] ? p : (a[0] ? {8'h00, p[7:0]} : {p[15:8], 8'h00}));
		end
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op, a, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		check(cmd_ready, !is_mem);
		repeat (8) @(posedge clk);
	endtask
	// ==========================================================
	// Watch settled outputs mid-cycle and pair each result with the oldest note
	always @(negedge clk) begin
		if (rst_n) begin
			m = mem;
			if (!m.wr) m.wdata = 16'h0000;
			if (mem.req && !req_prev) check(m, exp_mem.size() ? exp_mem.pop_front() : 'x);
			if (rdata_valid) check(rdata, exp_rd.size() ? exp_rd.pop_front() : 'x);
			if (ack_pulse && ack_hi == 0) acks++;
			if (!ack_pulse && ack_hi != 0) check(ack_hi, `DBGHC_ACK_CYC);
			ack_hi = ack_pulse ? ack_hi + 1 : 0;
		end
		req_prev = mem.req;
	end
	// Hang guard: far beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		mismatches++;
		final_report;
	end
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		fw_enable = 1'b0;
		bg_exit = 1'b0;
		hs = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		send(`DBGHC_OP_ACK_ON, 16'h0000, 16'h0000);
		check(ack_enabled, 1);
		// Every memory opcode, even then odd byte addresses, each after ready plus eight idle cycles
		for (int i = 0; i < 16; i++) begin
			p = 16'($random(seed));
			p[0] = ops[i % 8][3] ? 1'b0 : i[3];
			send(ops[i % 8], p, 16'($random(seed)));
		end
		send(`DBGHC_OP_ACK_OFF, 16'h0000, 16'h0000);
		check(ack_enabled, 0);
		send(`DBGHC_OP_RD_DBG_WORD, 16'hFF10, 16'h0000);
		send(8'h00, 16'h1234, 16'h5678);
		send(8'hA7, 16'hFF01, 16'h5678);
		send(`DBGHC_OP_BACKGROUND, 16'h0000, 16'h0000);
		check(background_debug_mode, 0);
		send(`DBGHC_OP_ACK_ON, 16'h0000, 16'h0000);
		fw_enable <= 1'b1;
		@(posedge clk);
		send(`DBGHC_OP_BACKGROUND, 16'h0000, 16'h0000);
		check({background_debug_mode, cpu_halt, dbg_window_on}, 3'h7);
		bg_exit <= 1'b1;
		@(posedge clk);
		bg_exit <= 1'b0;
		repeat (4) @(posedge clk);
		check({background_debug_mode, cpu_halt, dbg_window_on}, 3'h0);
		check(acks, exp_acks);
		check(exp_rd.size() + exp_mem.size(), 0);
		final_report;
	end
endmodule // tb_dbghc_decoder
